// ---- hdl/usb_ep_sfr_bank.sv ----
// Overview of operation
// R1: CPU fills transmit FIFOs, serial engine drains them
// R2: Serial engine fills receive FIFOs, CPU drains them
// R3: FIFO depths 8/8, hub EP1 1, fn EP1 16
// R4: Isochronous mode only on function endpoint 1
// R5: SOF pin low eight states per token
// R6: Banked access decoded by address and index
// R7: Four banks; hub endpoint 1 has none
// R8: Index 01 selects fn EP1, 02 fn EP2
// R9: Unselected banks keep their contents
// R10: Hub endpoint 1 has no receive data
// R11: Index top bit hub, low bits endpoint
// R12: Transmit, receive, control, status sets are banked
// R13: Device address register holds assigned address
// R14: Enable register gates each done interrupt
// R15: Done flags set only for non-isochronous endpoints
// R16: Receive count is five-bit byte count
// R17: Transmit count is five-bit byte count
// R18: Transmit data write pushes selected FIFO
// R19: Receive data read pops selected FIFO
// R20: Firmware uses read-modify-write on registers
// R21: Firmware saves and restores index in handlers
// R22: Three function and two hub endpoint pairs
// R23: Hub EP0 control and single-packet bits read one
// R24: Unimplemented banked access reads zero, ignores writes
`timescale 1ns/1ns
`default_nettype none

`include "usb_ep_bank_defines.svh"

module ep_byte_fifo
    import usb_ep_bank_pkg::*;
#(
    parameter int W = 8,
    parameter int DEPTH = 8,
    parameter int CW = 5
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic flush_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i,
    // Status
    output logic [CW-1:0] level_o,
    output logic full_next_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
    } fifo_s;

    fifo_s s_q;
    fifo_s s_d;
    logic push;
    logic pop;

    assign in_ready_o = s_q.cnt != CW'(DEPTH);
    assign out_valid_o = s_q.cnt != '0;
    assign out_data_o = s_q.mem[s_q.rp];
    assign level_o = s_q.cnt;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign full_next_o = s_d.cnt == CW'(DEPTH);

    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wp] = in_data_i;
            s_d.wp = (s_q.wp == PW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
        end
        if (pop)
            s_d.rp = (s_q.rp == PW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
        s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);
        if (reset_i || flush_i)
        begin
            s_d.wp = '0;
            s_d.rp = '0;
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge ref_clk_i)
        s_q <= s_d;

    a_fifo_bound: assert property (@(posedge ref_clk_i) // [R3]
        disable iff (reset_i) s_q.cnt <= CW'(DEPTH))
        else $error("FIFO level above its depth");

endmodule // ep_byte_fifo

module usb_ep_sfr_bank
    import usb_ep_bank_pkg::*;
#(
    parameter int DEPTH_SMALL = 8,
    parameter int DEPTH_LARGE = 16
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // CPU special function register access
    input wire sfr_req_s sfr_i,
    output logic [7:0] sfr_rdata_o,
    // Serial engine receive path
    input wire sie_rx_s sie_rx_i,
    output logic [`NUM_BANKS-1:0] sie_rx_ready_o,
    // Serial engine transmit path
    input wire sie_tx_req_s sie_tx_req_i,
    output sie_tx_s sie_tx_o,
    // Serial engine events
    input wire sie_done_s sie_done_i,
    input wire logic sie_sof_i,
    // Device status
    output logic [7:0] device_address_o,
    output logic function_irq_o,
    output logic sof_n_o
);
    localparam int NB = `NUM_BANKS; // [R7]

    ep_state_s s_q;
    ep_state_s s_d;
    bank_sel_s cpu_b;
    bank_sel_s rx_b;
    bank_sel_s tx_b;
    bank_sel_s done_b;
    logic [NB-1:0] tx_push, tx_pop, tx_flush, tx_rdy, tx_vld;
    logic [NB-1:0] rx_push, rx_pop, rx_flush, rx_rdy_c, rx_vld, rx_fn;
    bank_bytes_t tx_head, rx_head;
    logic [NB-1:0][4:0] tx_lvl, rx_lvl;

    // Banked access at one address for one bank
    function automatic logic at_bank(sfr_req_s r, bank_sel_s b,
                                     logic [7:0] a, logic [1:0] i);
        return r.addr == a && b.hit && b.idx == i;
    endfunction

    assign cpu_b = bank_of({s_q.sel[`SEL_HUB_BIT], s_q.sel[1:0]}); // [R11] [R22]
    assign rx_b = bank_of(sie_rx_i.ep);
    assign tx_b = bank_of(sie_tx_req_i.ep);
    assign done_b = bank_of(sie_done_i.ep);

    // ****************************************************************
    // Per-bank FIFO pairs
    // ****************************************************************
    for (genvar i = 0; i < NB; i++)
    begin : g_bank
        localparam int D = (i == `BANK_FN1) ? DEPTH_LARGE : DEPTH_SMALL; // [R3]
        assign tx_push[i] = sfr_i.wr
            && at_bank(sfr_i, cpu_b, `A_TX_DATA, 2'(i)); // [R18] [R6]
        assign rx_pop[i] = sfr_i.rd
            && at_bank(sfr_i, cpu_b, `A_RX_DATA, 2'(i)); // [R19] [R6]
        assign tx_flush[i] = sfr_i.wr && sfr_i.wdata[`FCTL_CLR_BIT]
            && at_bank(sfr_i, cpu_b, `A_TX_CTL, 2'(i));
        assign rx_flush[i] = sfr_i.wr && sfr_i.wdata[`FCTL_CLR_BIT]
            && at_bank(sfr_i, cpu_b, `A_RX_CTL, 2'(i));
        assign tx_pop[i] = sie_tx_req_i.req && tx_b.hit
            && tx_b.idx == 2'(i); // [R1]
        assign rx_push[i] = sie_rx_i.valid && rx_b.hit
            && rx_b.idx == 2'(i); // [R2]
        ep_byte_fifo #(.W(8), .DEPTH(D), .CW(5)) u_tx (
            .ref_clk_i(ref_clk_i), .reset_i(reset_i), .flush_i(tx_flush[i]),
            .in_valid_i(tx_push[i]), .in_data_i(sfr_i.wdata),
            .in_ready_o(tx_rdy[i]), .out_valid_o(tx_vld[i]),
            .out_data_o(tx_head[i]), .out_ready_i(tx_pop[i]),
            .level_o(tx_lvl[i]), .full_next_o()
        );
        ep_byte_fifo #(.W(8), .DEPTH(D), .CW(5)) u_rx (
            .ref_clk_i(ref_clk_i), .reset_i(reset_i), .flush_i(rx_flush[i]),
            .in_valid_i(rx_push[i]), .in_data_i(sie_rx_i.data),
            .in_ready_o(rx_rdy_c[i]), .out_valid_o(rx_vld[i]),
            .out_data_o(rx_head[i]), .out_ready_i(rx_pop[i]),
            .level_o(rx_lvl[i]), .full_next_o(rx_fn[i])
        );
    end

    // ****************************************************************
    // Register file and serial engine side
    // ****************************************************************
    always_comb
    begin
        logic [7:0] rv;
        logic [1:0] bi;
        rv = '0;
        bi = cpu_b.idx;
        s_d = s_q;

        // Firmware writes first so hardware updates win
        if (sfr_i.wr)
        begin
            unique case (sfr_i.addr)
                `A_DEV_ADDR: s_d.dev_addr = sfr_i.wdata; // [R13]
                `A_IRQ_EN: s_d.irq_en = sfr_i.wdata & `IRQ_MASK; // [R14]
                `A_IRQ_FLG: s_d.irq_flg = sfr_i.wdata & `IRQ_MASK;
                `A_SEL: s_d.sel = sfr_i.wdata & `SEL_MASK; // [R11]
                `A_EP_CTL: if (cpu_b.hit) // [R9] [R12] [R24]
                    s_d.ep_ctl[bi] = (bi == `BANK_HUB0) ?
                        sfr_i.wdata | `HUB_CTL_FORCE : sfr_i.wdata; // [R23]
                `A_RX_STAT: if (cpu_b.hit)
                    s_d.rx_stat[bi] = sfr_i.wdata;
                `A_TX_STAT: if (cpu_b.hit)
                    s_d.tx_stat[bi] = sfr_i.wdata;
                `A_RX_CTL: if (cpu_b.hit)
                    s_d.rx_ctl[bi] = sfr_i.wdata & ((bi == `BANK_FN1) ?
                        `FCTL_KEEP : `FCTL_NO_ISO); // [R4]
                `A_TX_CTL: if (cpu_b.hit)
                    s_d.tx_ctl[bi] = sfr_i.wdata & ((bi == `BANK_FN1) ?
                        `FCTL_KEEP : `FCTL_NO_ISO); // [R4]
                `A_RX_FLG: if (cpu_b.hit)
                    s_d.rx_err[bi] = sfr_i.wdata[1:0];
                `A_TX_FLG: if (cpu_b.hit)
                    s_d.tx_err[bi] = sfr_i.wdata[1:0];
                `A_TX_CNT: if (cpu_b.hit)
                    s_d.tx_cnt[bi] = sfr_i.wdata & `BC_MASK; // [R17]
                `A_TX_DATA:
                    if (cpu_b.hub1 && !s_q.hub1_full) // [R3] [R10]
                    begin
                        s_d.hub1_byte = sfr_i.wdata;
                        s_d.hub1_full = 1'b1;
                    end
                default: ;
            endcase
        end

        // Sticky overrun and underrun flags
        for (int i = 0; i < NB; i++)
        begin
            if (tx_push[i] && !tx_rdy[i])
                s_d.tx_err[i][`FLG_OVF_BIT] = 1'b1;
            if (rx_push[i] && !rx_rdy_c[i])
                s_d.rx_err[i][`FLG_OVF_BIT] = 1'b1;
            if (rx_pop[i] && !rx_vld[i])
                s_d.rx_err[i][`FLG_URF_BIT] = 1'b1;
            s_d.rx_rdy[i] = !rx_fn[i];
        end

        // Transaction results from the serial engine
        if (sie_done_i.valid && done_b.hit)
        begin
            if (sie_done_i.tx)
            begin
                s_d.tx_stat[done_b.idx][`STAT_ACK_BIT] = sie_done_i.ok;
                s_d.tx_stat[done_b.idx][`STAT_ERR_BIT] = !sie_done_i.ok;
            end
            else
            begin
                s_d.rx_stat[done_b.idx][`STAT_ACK_BIT] = sie_done_i.ok;
                s_d.rx_stat[done_b.idx][`STAT_ERR_BIT] = !sie_done_i.ok;
            end
            if (done_b.idx != `BANK_HUB0 && !(sie_done_i.tx ?
                s_q.tx_ctl[done_b.idx][`FCTL_ISO_BIT] :
                s_q.rx_ctl[done_b.idx][`FCTL_ISO_BIT])) // [R15]
                s_d.irq_flg[{done_b.idx, !sie_done_i.tx}] = 1'b1;
        end

        // Transmit byte handed to the serial engine
        s_d.tx_valid = 1'b0;
        if (sie_tx_req_i.req)
        begin
            if (tx_b.hit)
            begin
                s_d.tx_valid = tx_vld[tx_b.idx]; // [R1]
                s_d.tx_data = tx_head[tx_b.idx];
            end
            else if (tx_b.hub1)
            begin
                s_d.tx_valid = s_q.hub1_full;
                s_d.tx_data = s_q.hub1_byte;
                s_d.hub1_full = s_d.hub1_full && !s_q.hub1_full;
            end
        end

        // Read data
        if (sfr_i.rd)
        begin
            unique case (sfr_i.addr)
                `A_DEV_ADDR: rv = s_q.dev_addr;
                `A_IRQ_EN: rv = s_q.irq_en;
                `A_IRQ_FLG: rv = s_q.irq_flg;
                `A_SEL: rv = s_q.sel;
                `A_EP_CTL: rv = s_q.ep_ctl[bi];
                `A_RX_STAT: rv = s_q.rx_stat[bi];
                `A_TX_STAT: rv = s_q.tx_stat[bi];
                `A_RX_CTL: rv = s_q.rx_ctl[bi];
                `A_TX_CTL: rv = s_q.tx_ctl[bi];
                `A_RX_DATA: rv = rx_head[bi]; // [R19]
                `A_RX_FLG: rv = {4'h0, !rx_vld[bi], !rx_rdy_c[bi],
                                 s_q.rx_err[bi]};
                `A_TX_FLG: rv = {4'h0, !tx_vld[bi], !tx_rdy[bi],
                                 s_q.tx_err[bi]};
                `A_RX_CNT: rv = {3'h0, rx_lvl[bi]}; // [R16]
                `A_TX_CNT: rv = s_q.tx_cnt[bi]; // [R17]
                default: rv = '0;
            endcase
            if (!cpu_b.hit && sfr_i.addr >= `A_EP_CTL
                && sfr_i.addr != `A_SEL)
                rv = '0; // [R24] [R10]
            s_d.rdata = rv;
        end

        // Start-of-frame strobe
        if (sie_sof_i)
            s_d.sof_cnt = 4'(`SOF_CYCLES); // [R5]
        else if (s_q.sof_cnt != '0)
            s_d.sof_cnt = s_q.sof_cnt - 4'h1;
        s_d.sof_n = s_d.sof_cnt == '0;
        s_d.irq = |(s_d.irq_flg & s_d.irq_en); // [R14]
        if (reset_i)
        begin
            s_d = '0;
            s_d.ep_ctl[`BANK_FN0] = `CTL_RST_EP0;
            s_d.ep_ctl[`BANK_HUB0] = `CTL_RST_EP0 | `HUB_CTL_FORCE; // [R23]
            s_d.ep_ctl[`BANK_FN1] = `CTL_RST_EPN;
            s_d.ep_ctl[`BANK_FN2] = `CTL_RST_EPN;
            s_d.rx_rdy = '1;
            s_d.sof_n = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i)
        s_q <= s_d;

    assign sfr_rdata_o = s_q.rdata;
    assign sie_rx_ready_o = s_q.rx_rdy;
    assign sie_tx_o = {s_q.tx_valid, s_q.tx_data};
    assign device_address_o = s_q.dev_addr;
    assign function_irq_o = s_q.irq;
    assign sof_n_o = s_q.sof_n;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence sof_low_run;
        !sof_n_o [*8];
    endsequence
    sequence sof_alone;
        sie_sof_i ##1 !sie_sof_i [*8];
    endsequence
    a_sof_low_width: assert property (sie_sof_i |=> sof_low_run) // [R5]
        else $error("SOF pin not low for eight states");
    a_sof_end_high: assert property (sof_alone |=> sof_n_o) // [R5]
        else $error("SOF pin low past eight states");
    a_tx_push_count: assert property (tx_push[2] && tx_rdy[2] // [R18]
        && !tx_pop[2] && !tx_flush[2]
        |=> tx_lvl[2] == $past(tx_lvl[2]) + 5'h1)
        else $error("Transmit data write not pushed");
    a_rx_fill_count: assert property (rx_push[1] && rx_rdy_c[1] // [R2]
        && !rx_pop[1] && !rx_flush[1]
        |=> rx_lvl[1] == $past(rx_lvl[1]) + 5'h1)
        else $error("Receive byte not stored");
    a_rx_read_data: assert property (rx_pop[1] && rx_vld[1] // [R19]
        && !rx_push[1] && !rx_flush[1]
        |=> sfr_rdata_o == $past(rx_head[1])
            && rx_lvl[1] == $past(rx_lvl[1]) - 5'h1)
        else $error("Receive read returned wrong byte");
    a_tx_drain_data: assert property (tx_pop[2] && tx_vld[2] // [R1]
        |=> sie_tx_o.valid && sie_tx_o.data == $past(tx_head[2]))
        else $error("Transmit byte not handed to engine");
    a_bank_kept: assert property (!(sfr_i.wr && cpu_b.hit // [R9]
        && cpu_b.idx == `BANK_FN1) |=> $stable(s_q.ep_ctl[`BANK_FN1]))
        else $error("Unselected bank changed");
    a_hub_ctl_ones: assert property ( // [R23]
        s_q.ep_ctl[`BANK_HUB0][`CTL_CONTROL_ENDPOINT_CONFIG_BIT]
        && s_q.ep_ctl[`BANK_HUB0][`CTL_SPM_BIT])
        else $error("Hub endpoint 0 fixed bits cleared");
    a_empty_bank_read: assert property (sfr_i.rd && !cpu_b.hit // [R24]
        && sfr_i.addr == `A_EP_CTL |=> sfr_rdata_o == 8'h00)
        else $error("Unimplemented bank read not zero");
    a_select_fn: assert property ((s_q.sel == `SEL_FN_EP1 // [R8]
        |-> cpu_b.hit && cpu_b.idx == `BANK_FN1) and (s_q.sel == `SEL_FN_EP2
        |-> cpu_b.hit && cpu_b.idx == `BANK_FN2))
        else $error("Index decode chose wrong bank");
    a_irq_done: assert property (sie_done_i.valid && sie_done_i.tx // [R15]
        && sie_done_i.ep == 3'h0 && !s_q.tx_ctl[0][`FCTL_ISO_BIT]
        |=> s_q.irq_flg[0] ##1 function_irq_o == s_q.irq_en[0])
        else $error("Transmit done flag not set");
    a_addr_store: assert property (sfr_i.wr // [R13]
        && sfr_i.addr == `A_DEV_ADDR
        |=> device_address_o == $past(sfr_i.wdata))
        else $error("Device address not stored");

endmodule // usb_ep_sfr_bank

`default_nettype wire

// ---- hdl/usb_ep_bank_defines.svh ----
`ifndef USB_EP_BANK_DEFINES_SVH
`define USB_EP_BANK_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define A_DEV_ADDR 8'h8f
`define A_IRQ_EN 8'ha2
`define A_IRQ_FLG 8'hc0
`define A_EP_CTL 8'he1
`define A_RX_STAT 8'he2
`define A_RX_DATA 8'he3
`define A_RX_CTL 8'he4
`define A_RX_FLG 8'he5
`define A_RX_CNT 8'he6
`define A_SEL 8'hf1
`define A_TX_DATA 8'hf3
`define A_TX_CTL 8'hf4
`define A_TX_FLG 8'hf5
`define A_TX_CNT 8'hf6
`define A_TX_STAT 8'hfa

// ****************************************************************
// Field layouts and masks
// ****************************************************************
`define SEL_HUB_BIT 7
`define SEL_MASK 8'h83
`define SEL_FN_EP1 8'h01
`define SEL_FN_EP2 8'h02
`define IRQ_MASK 8'h3f
`define CTL_CONTROL_ENDPOINT_CONFIG_BIT 5
`define CTL_SPM_BIT 4
`define HUB_CTL_FORCE 8'h30
`define FCTL_CLR_BIT 7
`define FCTL_ISO_BIT 3
`define FCTL_KEEP 8'h7f
`define FCTL_NO_ISO 8'h77
`define FLG_OVF_BIT 0
`define FLG_URF_BIT 1
`define STAT_ACK_BIT 0
`define STAT_ERR_BIT 1
`define BC_MASK 8'h1f

// ****************************************************************
// Banks, endpoints and reset values
// ****************************************************************
`define NUM_BANKS 4
`define HUB_EP0 2'h0
`define HUB_EP1 2'h1
`define FN_EP_NONE 2'h3
`define BANK_FN0 2'h0
`define BANK_FN1 2'h1
`define BANK_FN2 2'h2
`define BANK_HUB0 2'h3
`define CTL_RST_EP0 8'h35
`define CTL_RST_EPN 8'h10

// ****************************************************************
// Start-of-frame strobe timing
// ****************************************************************
`define SOF_STATES 8
`define CLKS_PER_STATE 1
`define SOF_CYCLES (`SOF_STATES * `CLKS_PER_STATE)

`endif

// ---- hdl/usb_ep_bank_pkg.sv ----
`include "usb_ep_bank_defines.svh"

package usb_ep_bank_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;

    typedef struct packed {
        logic hub;
        logic [1:0] num;
    } ep_code_s;

    typedef struct packed {
        logic hit;
        logic hub1;
        logic [1:0] idx;
    } bank_sel_s;

    typedef struct packed {
        logic valid;
        ep_code_s ep;
        logic [7:0] data;
    } sie_rx_s;

    typedef struct packed {
        logic req;
        ep_code_s ep;
    } sie_tx_req_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } sie_tx_s;

    typedef struct packed {
        logic valid;
        logic tx;
        logic ok;
        ep_code_s ep;
    } sie_done_s;

    typedef logic [`NUM_BANKS-1:0][7:0] bank_bytes_t;

    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] dev_addr;
        logic [7:0] irq_en;
        logic [7:0] irq_flg;
        bank_bytes_t ep_ctl;
        bank_bytes_t rx_stat;
        bank_bytes_t tx_stat;
        bank_bytes_t rx_ctl;
        bank_bytes_t tx_ctl;
        bank_bytes_t tx_cnt;
        logic [`NUM_BANKS-1:0][1:0] rx_err;
        logic [`NUM_BANKS-1:0][1:0] tx_err;
        logic hub1_full;
        logic [7:0] hub1_byte;
        logic [7:0] rdata;
        logic tx_valid;
        logic [7:0] tx_data;
        logic [`NUM_BANKS-1:0] rx_rdy;
        logic [3:0] sof_cnt;
        logic sof_n;
        logic irq;
    } ep_state_s;

    // Endpoint code to register bank
    function automatic bank_sel_s bank_of(ep_code_s e);
        bank_sel_s b;
        b = '0;
        if (e.hub)
        begin
            if (e.num == `HUB_EP0)
            begin
                b.hit = 1'b1;
                b.idx = `BANK_HUB0;
            end
            else if (e.num == `HUB_EP1)
                b.hub1 = 1'b1;
        end
        else if (e.num != `FN_EP_NONE)
        begin
            b.hit = 1'b1;
            b.idx = e.num; // [R8]
        end
        return b;
    endfunction

endpackage

// ---- bench/sie_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module sie_model
    import usb_ep_bank_pkg::*;
(
    // Clock
    input wire logic ref_clk_i,
    // Toward the bank
    output sie_rx_s rx_o,
    output sie_tx_req_s tx_req_o,
    output sie_done_s done_o,
    output logic sof_o,
    // From the bank
    input wire sie_tx_s tx_i
);
    initial
    begin
        rx_o = '0;
        tx_req_o = '0;
        done_o = '0;
        sof_o = 1'b0;
    end

    // Host byte into a receive FIFO; data inverted once released
    task automatic push_rx(input ep_code_s ep, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        rx_o = '{1'b1, ep, d};
        @(posedge ref_clk_i);
        #1;
        rx_o = '{1'b0, ep, ~d};
    endtask

    // One byte drained for sending
    task automatic pull_tx(input ep_code_s ep, output logic [7:0] d,
                           output logic v);
        @(posedge ref_clk_i);
        #1;
        tx_req_o = '{1'b1, ep};
        @(posedge ref_clk_i);
        #1;
        tx_req_o = '{1'b0, ~ep};
        v = tx_i.valid;
        d = tx_i.data;
    endtask

    // Transaction end or frame start
    task automatic done_evt(input logic tx, input logic ok,
                            input ep_code_s ep);
        @(posedge ref_clk_i);
        #1;
        done_o = '{1'b1, tx, ok, ep};
        @(posedge ref_clk_i);
        #1;
        done_o = '{1'b0, ~tx, ~ok, ~ep};
    endtask

    task automatic sof_pulse();
        @(posedge ref_clk_i);
        #1;
        sof_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        sof_o = 1'b0;
    endtask
endmodule // sie_model

`default_nettype wire

// ---- bench/test_usb_ep_sfr_bank.sv ----
`timescale 1ns/1ns
`default_nettype none

`include "usb_ep_bank_defines.svh"

`define CHECK_EQ(act, exp) \
    begin \
        comparisons++; \
        if ((act) !== (exp)) \
        begin \
            num_errors++; \
            $display("mismatch at %0t: got %h expected %h", $time, act, exp); \
        end \
    end

module test_usb_ep_sfr_bank
    import usb_ep_bank_pkg::*;
;
    logic ref_clk_i;
    logic reset_i;
    sfr_req_s sfr;
    logic [7:0] rdata;
    sie_rx_s rx;
    sie_tx_req_s txq;
    sie_tx_s tx;
    sie_done_s done;
    logic sof;
    logic sof_n;
    logic irq;
    logic [3:0] rx_rdy;
    logic [7:0] dev_addr;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    usb_ep_sfr_bank u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .sfr_i(sfr), .sfr_rdata_o(rdata), .sie_rx_i(rx),
        .sie_rx_ready_o(rx_rdy), .sie_tx_req_i(txq), .sie_tx_o(tx),
        .sie_done_i(done), .sie_sof_i(sof), .device_address_o(dev_addr),
        .function_irq_o(irq), .sof_n_o(sof_n));

    sie_model u_sie (.ref_clk_i(ref_clk_i), .rx_o(rx), .tx_req_o(txq),
        .done_o(done), .sof_o(sof), .tx_i(tx));

    // ****************************************************************
    // Register access
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        sfr = '{1'b1, 1'b0, a, d};
        @(posedge ref_clk_i);
        #1;
        sfr = '{1'b0, 1'b0, a, ~d};
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        #1;
        sfr = '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk_i);
        #1;
        sfr = '{1'b0, 1'b0, a, 8'hff};
        `CHECK_EQ(rdata, e);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        `CHECK_EQ(sof_n, 1'b1);
        `CHECK_EQ(rx_rdy, 4'hf);
        rchk(`A_EP_CTL, `CTL_RST_EP0);
        wr(`A_SEL, 8'h80);
        rchk(`A_EP_CTL, `CTL_RST_EP0);
        wr(`A_SEL, `SEL_FN_EP1);
        rchk(`A_EP_CTL, `CTL_RST_EPN);
        wr(`A_SEL, `SEL_FN_EP2);
        rchk(`A_EP_CTL, `CTL_RST_EPN);
        $display("test reset done");
    endtask

    task automatic t_banks();
        logic [7:0] sels [4] = '{8'h00, 8'h01, 8'h02, 8'h80};
        for (int i = 0; i < 4; i++)
        begin
            wr(`A_SEL, sels[i]);
            wr(`A_TX_CNT, 8'he0 | 8'(i * 7 + 3));
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(`A_SEL, sels[i]);
            rchk(`A_TX_CNT, 8'(i * 7 + 3));
        end
        wr(`A_SEL, 8'h81);
        rchk(`A_TX_CNT, 8'h00);
        rchk(`A_RX_DATA, 8'h00);
        rchk(`A_EP_CTL, 8'h00);
        wr(`A_TX_CNT, 8'hff);
        wr(`A_SEL, 8'hff);
        rchk(`A_SEL, `SEL_MASK);
        wr(`A_SEL, 8'h03);
        rchk(`A_TX_CNT, 8'h00);
        wr(`A_SEL, 8'h00);
        rchk(`A_TX_CNT, 8'h03);
        wr(`A_DEV_ADDR, 8'h5a);
        rchk(`A_DEV_ADDR, 8'h5a);
        `CHECK_EQ(dev_addr, 8'h5a);
        $display("test banks done");
    endtask

    task automatic t_tx_fifo();
        logic [7:0] d;
        logic v;
        wr(`A_SEL, `SEL_FN_EP2);
        for (int i = 0; i < 9; i++)
            wr(`A_TX_DATA, 8'h40 + 8'(i));
        rchk(`A_TX_FLG, 8'h05);
        for (int i = 0; i < 9; i++)
        begin
            u_sie.pull_tx(3'b010, d, v);
            `CHECK_EQ(v, 1'(i < 8));
            if (i < 8)
                `CHECK_EQ(d, 8'h40 + 8'(i));
        end
        wr(`A_SEL, 8'h81);
        wr(`A_TX_DATA, 8'haa);
        wr(`A_TX_DATA, 8'hbb);
        u_sie.pull_tx(3'b101, d, v);
        `CHECK_EQ(d, 8'haa);
        u_sie.pull_tx(3'b101, d, v);
        `CHECK_EQ(v, 1'b0);
        $display("test tx fifo done");
    endtask

    task automatic t_rx_fifo();
        for (int i = 0; i < 17; i++)
            u_sie.push_rx(3'b001, 8'h80 + 8'(i));
        `CHECK_EQ(rx_rdy, 4'hd);
        wr(`A_SEL, `SEL_FN_EP1);
        rchk(`A_RX_CNT, 8'h10);
        rchk(`A_RX_FLG, 8'h05);
        for (int i = 0; i < 16; i++)
            rchk(`A_RX_DATA, 8'h80 + 8'(i));
        rchk(`A_RX_CNT, 8'h00);
        `CHECK_EQ(rx_rdy, 4'hf);
        $display("test rx fifo done");
    endtask

    task automatic t_sof();
        int n = 0;
        u_sie.sof_pulse();
        repeat (12)
        begin
            if (sof_n === 1'b0)
                n++;
            @(posedge ref_clk_i);
            #1;
        end
        `CHECK_EQ(n, `SOF_CYCLES);
        $display("test sof done");
    endtask

    task automatic t_irq();
        rchk(`A_SEL, `SEL_FN_EP1);
        wr(`A_SEL, 8'h00);
        wr(`A_IRQ_EN, 8'h01);
        u_sie.done_evt(1'b1, 1'b1, 3'b000);
        @(posedge ref_clk_i);
        #1;
        `CHECK_EQ(irq, 1'b1);
        rchk(`A_IRQ_FLG, 8'h01);
        rchk(`A_TX_STAT, 8'h01);
        wr(`A_SEL, `SEL_FN_EP2);
        wr(`A_TX_CTL, 8'h08);
        rchk(`A_TX_CTL, 8'h00);
        wr(`A_SEL, `SEL_FN_EP1);
        wr(`A_TX_CTL, 8'h08);
        rchk(`A_TX_CTL, 8'h08);
        u_sie.done_evt(1'b1, 1'b1, 3'b001);
        rchk(`A_IRQ_FLG, 8'h01);
        wr(`A_IRQ_EN, 8'h00);
        @(posedge ref_clk_i);
        #1;
        `CHECK_EQ(irq, 1'b0);
        u_sie.done_evt(1'b0, 1'b1, 3'b010);
        rchk(`A_IRQ_FLG, 8'h21);
        wr(`A_IRQ_FLG, 8'h21 & 8'hfe);
        rchk(`A_IRQ_FLG, 8'h20);
        rchk(`A_SEL, `SEL_FN_EP1);
        $display("test irq done");
    endtask

    // ****************************************************************
    // Run control
    // ****************************************************************
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        ref_clk_i = 1'b0;
        forever
            #20 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    initial
    begin
        reset_i = 1'b1;
        sfr = '0;
        repeat (6) @(posedge ref_clk_i);
        #1;
        reset_i = 1'b0;
        t_reset();
        t_banks();
        t_tx_fifo();
        t_rx_fifo();
        t_sof();
        t_irq();
        end_of_test();
    end
endmodule // test_usb_ep_sfr_bank

`default_nettype wire
